// file: verilog/frlt_pkg.sv
// Shared constants, types and helpers for the flash read latency link
// What this block does
// - Top single-rate band to 133 MHz, code 10b
// - Host never sends normal read at top band
// - Top band fast read: 0 mode, 8 dummy
// - Host never sends dual/quad output reads there
// - Host never sends dual/quad I/O reads there
// - Double-rate parameter ID 9Ah, length 2Ah
// - Five rows of eight bytes, header "FC"
// - Fast double-rate read opcodes 0Dh and 0Eh
// - Dual I/O double-rate opcodes BDh and BEh
// - Quad I/O double-rate opcodes EDh and EEh
// - Double-rate up to 50 MHz uses code 11b
// - 50 MHz fast double-rate: 4 mode, 1 dummy
// - 50 MHz dual double-rate: 2 mode, 2 dummy
// - 50 MHz quad double-rate: 1 mode, 3 dummy
// - Double-rate to 66 MHz uses code 00b
package frlt_pkg;
  // Single-rate opcodes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_DOUT = 8'h3b;
  localparam logic [7:0] OP_QOUT = 8'h6b;
  localparam logic [7:0] OP_DIO = 8'hbb;
  localparam logic [7:0] OP_QIO = 8'heb;
  localparam logic [7:0] OP_TBL = 8'h5b;
  // Double-rate opcodes
  localparam logic [7:0] OP_FDDR3 = 8'h0d;
  localparam logic [7:0] OP_FDDR4 = 8'h0e;
  localparam logic [7:0] OP_DDIO3 = 8'hbd;
  localparam logic [7:0] OP_DDIO4 = 8'hbe;
  localparam logic [7:0] OP_QDIO3 = 8'hed;
  localparam logic [7:0] OP_QDIO4 = 8'hee;
  // Band limits in MHz and latency codes
  localparam logic [7:0] LIM_SDR_TOP = 8'h85;
  localparam logic [7:0] LIM_DDR50 = 8'h32;
  localparam logic [7:0] LIM_DDR66 = 8'h42;
  localparam logic [1:0] CODE_SDR_TOP = 2'h2;
  localparam logic [1:0] CODE_DDR50 = 2'h3;
  localparam logic [1:0] CODE_DDR66 = 2'h0;
  // Mode and dummy cycle counts; all ones marks unsupported
  localparam logic [7:0] NOSUP = 8'hff;
  localparam logic [7:0] M_FAST = 8'h00;
  localparam logic [7:0] D_FAST = 8'h08;
  localparam logic [7:0] M_TBL = 8'h00;
  localparam logic [7:0] D_TBL = 8'h08;
  localparam logic [7:0] M_F50 = 8'h04;
  localparam logic [7:0] D_F50 = 8'h01;
  localparam logic [7:0] M_D50 = 8'h02;
  localparam logic [7:0] D_D50 = 8'h02;
  localparam logic [7:0] M_Q50 = 8'h01;
  localparam logic [7:0] D_Q50 = 8'h03;
  localparam logic [7:0] M_F66 = 8'h04;
  localparam logic [7:0] D_F66 = 8'h02;
  localparam logic [7:0] M_D66 = 8'h02;
  localparam logic [7:0] D_D66 = 8'h04;
  localparam logic [7:0] M_Q66 = 8'h01;
  localparam logic [7:0] D_Q66 = 8'h06;
  // Parameter table header
  localparam logic [7:0] TBL_ID = 8'h9a;
  localparam logic [7:0] TBL_LEN = 8'h2a;
  localparam logic [7:0] TBL_ROWS = 8'h05;
  localparam logic [7:0] TBL_ROWLEN = 8'h08;
  localparam logic [7:0] TBL_HDR_F = 8'h46;
  localparam logic [7:0] TBL_HDR_C = 8'h43;
  // Host register map and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0c;
  localparam int CTRL_START = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_CODE = 4;
  // Serial clock timing: half period in pclk cycles
  localparam int PCLK_NS = 5;
  localparam int SCK_HALF = 4;
  localparam int SCK_MHZ = 1000 / (2 * SCK_HALF * PCLK_NS);
  localparam logic [7:0] CMD_CYC = 8'h08;

  typedef enum logic [2:0] {
    PH_IDLE, PH_CMD, PH_ADDR, PH_MODE, PH_DUMMY, PH_DATA, PH_DONE
  } frlt_ph_e;

  // Phase that follows the last cycle of the current one
  function automatic frlt_ph_e frlt_nph(input frlt_ph_e cur,
      input logic [7:0] m, input logic [7:0] d);
    case (cur)
      PH_CMD: frlt_nph = PH_ADDR;
      PH_ADDR: frlt_nph = (m != 8'h00) ? PH_MODE :
                          (d != 8'h00) ? PH_DUMMY : PH_DATA;
      PH_MODE: frlt_nph = (d != 8'h00) ? PH_DUMMY : PH_DATA;
      PH_DUMMY: frlt_nph = PH_DATA;
      PH_DATA: frlt_nph = PH_DONE;
      default: frlt_nph = PH_IDLE;
    endcase
  endfunction : frlt_nph

  // Cycle count of a phase
  function automatic logic [7:0] frlt_ncnt(input frlt_ph_e ph,
      input logic [7:0] m, input logic [7:0] d, input logic [7:0] ac,
      input logic [7:0] dc);
    case (ph)
      PH_ADDR: frlt_ncnt = ac;
      PH_MODE: frlt_ncnt = m;
      PH_DUMMY: frlt_ncnt = d;
      PH_DATA: frlt_ncnt = dc;
      default: frlt_ncnt = 8'h00;
    endcase
  endfunction : frlt_ncnt

  // Top bits of a byte onto the lines; single line uses io1 from device
  function automatic logic [3:0] frlt_put(input logic [7:0] v,
      input logic [2:0] lanes, input logic dev);
    case (lanes)
      3'h4: frlt_put = v[7:4];
      3'h2: frlt_put = {2'h0, v[7:6]};
      default: frlt_put = dev ? {2'h0, v[7], 1'h0} : {3'h0, v[7]};
    endcase
  endfunction : frlt_put

  // Bits taken from the lines, right aligned
  function automatic logic [3:0] frlt_get(input logic [3:0] io,
      input logic [2:0] lanes, input logic from_dev);
    case (lanes)
      3'h4: frlt_get = io;
      3'h2: frlt_get = {2'h0, io[1:0]};
      default: frlt_get = {3'h0, from_dev ? io[1] : io[0]};
    endcase
  endfunction : frlt_get

  // Double-rate latency parameter bytes
  function automatic logic [7:0] frlt_tbl(input logic [7:0] i);
    case (i)
      8'h00: frlt_tbl = TBL_ID;
      8'h01: frlt_tbl = TBL_LEN;
      8'h02: frlt_tbl = TBL_ROWS;
      8'h03: frlt_tbl = TBL_ROWLEN;
      8'h04: frlt_tbl = TBL_HDR_F;
      8'h05: frlt_tbl = TBL_HDR_C;
      8'h06: frlt_tbl = OP_FDDR3;
      8'h07: frlt_tbl = OP_FDDR4;
      8'h08: frlt_tbl = OP_DDIO3;
      8'h09: frlt_tbl = OP_DDIO4;
      8'h0a: frlt_tbl = OP_QDIO3;
      8'h0b: frlt_tbl = OP_QDIO4;
      8'h0c: frlt_tbl = LIM_DDR50;
      8'h0d: frlt_tbl = {6'h00, CODE_DDR50};
      8'h0e: frlt_tbl = M_F50;
      8'h0f: frlt_tbl = D_F50;
      8'h10: frlt_tbl = M_D50;
      8'h11: frlt_tbl = D_D50;
      8'h12: frlt_tbl = M_Q50;
      8'h13: frlt_tbl = D_Q50;
      8'h14: frlt_tbl = LIM_DDR66;
      8'h15: frlt_tbl = {6'h00, CODE_DDR66};
      default: frlt_tbl = NOSUP;
    endcase
  endfunction : frlt_tbl
endpackage : frlt_pkg

// file: verilog/frlt_if.sv
// Serial link between the read host and the flash device
`timescale 1ns/1ps
interface frlt_if;
  logic sck;
  logic cs_n;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe;
  logic [3:0] io;

  // Resolved lines; undriven lines float high as with a pull-up
  assign io = (h_io_o & h_io_oe) | (d_io_o & d_io_oe & ~h_io_oe) |
              ~(h_io_oe | d_io_oe);

  modport host (output sck, output cs_n, output h_io_o, output h_io_oe,
                input io);
  modport dev (input sck, input cs_n, input io, output d_io_o,
               output d_io_oe);
endinterface : frlt_if

// file: verilog/frlt_lookup.sv
// Latency entry lookup by opcode and latency code
`timescale 1ns/1ps
module frlt_lookup (
  input wire logic [7:0] op, // Read opcode
  input wire logic [1:0] code, // Latency code in force
  output logic ok, // Opcode served at this code
  output logic ddr, // Double-rate command
  output logic [2:0] lanes, // Lines for address and data
  output logic [2:0] abytes, // Address bytes
  output logic [7:0] mode, // Mode cycles
  output logic [7:0] dummy // Dummy cycles
);
  // Entry selection; anything without an entry reads as unsupported
  always_comb begin
    ddr = 1'h0;
    lanes = 3'h1;
    abytes = 3'h3;
    mode = frlt_pkg::NOSUP;
    dummy = frlt_pkg::NOSUP;
    case (op)
      frlt_pkg::OP_FAST: begin
        if (code == frlt_pkg::CODE_SDR_TOP) begin
          mode = frlt_pkg::M_FAST;
          dummy = frlt_pkg::D_FAST;
        end
      end
      frlt_pkg::OP_TBL: begin
        mode = frlt_pkg::M_TBL;
        dummy = frlt_pkg::D_TBL;
      end
      frlt_pkg::OP_FDDR3, frlt_pkg::OP_FDDR4: begin
        ddr = 1'h1;
        abytes = (op == frlt_pkg::OP_FDDR4) ? 3'h4 : 3'h3;
        if (code == frlt_pkg::CODE_DDR50) begin
          mode = frlt_pkg::M_F50;
          dummy = frlt_pkg::D_F50;
        end else if (code == frlt_pkg::CODE_DDR66) begin
          mode = frlt_pkg::M_F66;
          dummy = frlt_pkg::D_F66;
        end
      end
      frlt_pkg::OP_DDIO3, frlt_pkg::OP_DDIO4: begin
        ddr = 1'h1;
        lanes = 3'h2;
        abytes = (op == frlt_pkg::OP_DDIO4) ? 3'h4 : 3'h3;
        if (code == frlt_pkg::CODE_DDR50) begin
          mode = frlt_pkg::M_D50;
          dummy = frlt_pkg::D_D50;
        end else if (code == frlt_pkg::CODE_DDR66) begin
          mode = frlt_pkg::M_D66;
          dummy = frlt_pkg::D_D66;
        end
      end
      frlt_pkg::OP_QDIO3, frlt_pkg::OP_QDIO4: begin
        ddr = 1'h1;
        lanes = 3'h4;
        abytes = (op == frlt_pkg::OP_QDIO4) ? 3'h4 : 3'h3;
        if (code == frlt_pkg::CODE_DDR50) begin
          mode = frlt_pkg::M_Q50;
          dummy = frlt_pkg::D_Q50;
        end else if (code == frlt_pkg::CODE_DDR66) begin
          mode = frlt_pkg::M_Q66;
          dummy = frlt_pkg::D_Q66;
        end
      end
      // Normal, dual/quad out and dual/quad I/O: no top-band entry
      default: begin
        mode = frlt_pkg::NOSUP;
      end
    endcase
  end

  assign ok = (mode != frlt_pkg::NOSUP) && (dummy != frlt_pkg::NOSUP);
endmodule : frlt_lookup

// file: verilog/frlt_dev.sv
// Flash device end: decodes read frames on the serial clock
`timescale 1ns/1ps
module frlt_dev (
  frlt_if.dev lnk, // Serial link from the host
  input wire logic [1:0] lat_code, // Latency code configured in the part
  output logic [7:0] cur_cmd, // Opcode of the current frame
  output logic refused // Current opcode not served
);
  frlt_pkg::frlt_ph_e st_q;
  frlt_pkg::frlt_ph_e st_d;
  logic [7:0] cmd_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] sh_q;
  logic [7:0] bidx_q;
  logic [7:0] byte_v;
  logic [31:0] addr_q;
  logic [2:0] bc_q;
  logic [7:0] ncmd;
  logic [7:0] op;
  logic [7:0] acyc;
  logic ok;
  logic [2:0] lanes;
  logic [2:0] abytes;
  logic [7:0] mode;
  logic [7:0] dummy;

  // Opcode is judged on its last bit, before it is stored
  assign ncmd = {cmd_q[6:0], lnk.io[0]};
  assign op = (st_q == frlt_pkg::PH_CMD) ? ncmd : cmd_q;
  assign acyc = 8'({abytes, 3'h0} / lanes);
  assign byte_v = (cmd_q == frlt_pkg::OP_TBL) ?
                  frlt_pkg::frlt_tbl(addr_q[7:0] + bidx_q) :
                  addr_q[7:0] + bidx_q;

  frlt_lookup u_lookup (
    .op(op),
    .code(lat_code),
    .ok(ok),
    .ddr(),
    .lanes(lanes),
    .abytes(abytes),
    .mode(mode),
    .dummy(dummy)
  );

  // Phase sequencing, one step per rising serial clock
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q - 8'h01;
    if (st_q != frlt_pkg::PH_DATA && st_q != frlt_pkg::PH_IDLE &&
        cnt_q == 8'h01) begin
      st_d = frlt_pkg::frlt_nph(st_q, mode, dummy);
      if (st_q == frlt_pkg::PH_CMD && !ok) begin
        st_d = frlt_pkg::PH_IDLE;
      end
      cnt_d = frlt_pkg::frlt_ncnt(st_d, mode, dummy, acyc, 8'h00);
    end
  end

  // Frame state; chip select high ends the frame even without clocks
  always_ff @(posedge lnk.sck or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      st_q <= frlt_pkg::PH_CMD;
      cnt_q <= frlt_pkg::CMD_CYC;
      cmd_q <= 8'h00;
      addr_q <= 32'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      if (st_q == frlt_pkg::PH_CMD) begin
        cmd_q <= ncmd;
      end
      if (st_q == frlt_pkg::PH_ADDR) begin
        addr_q <= (addr_q << lanes) |
                  {28'h0, frlt_pkg::frlt_get(lnk.io, lanes, 1'h0)};
      end
    end
  end

  // Status seen by local logic
  always_ff @(posedge lnk.sck or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      cur_cmd <= 8'h00;
      refused <= 1'h0;
    end else if (st_q == frlt_pkg::PH_CMD && cnt_q == 8'h01) begin
      cur_cmd <= ncmd;
      refused <= !ok;
    end
  end

  // Read data out; lines stay released until latency is spent
  always_ff @(posedge lnk.sck or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      sh_q <= 8'h00;
      bc_q <= 3'h0;
      bidx_q <= 8'h00;
      lnk.d_io_o <= 4'h0;
      lnk.d_io_oe <= 4'h0;
    end else if (st_d == frlt_pkg::PH_DATA) begin
      lnk.d_io_oe <= frlt_pkg::frlt_put(8'hff, lanes, 1'h1);
      if (st_q != frlt_pkg::PH_DATA || bc_q == 3'h0) begin
        lnk.d_io_o <= frlt_pkg::frlt_put(byte_v, lanes, 1'h1);
        sh_q <= byte_v << lanes;
        bc_q <= 3'(4'h8 / {1'h0, lanes} - 4'h1);
        bidx_q <= bidx_q + 8'h01;
      end else begin
        lnk.d_io_o <= frlt_pkg::frlt_put(sh_q, lanes, 1'h1);
        sh_q <= sh_q << lanes;
        bc_q <= bc_q - 3'h1;
      end
    end
  end
endmodule : frlt_dev

// file: verilog/frlt_host.sv
// Read host: APB registers, serial clock divider and read sequencer
`timescale 1ns/1ps
module frlt_host (
  input wire logic pclk, // System clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  frlt_if.host lnk // Serial link to the device
);
  frlt_pkg::frlt_ph_e st_q;
  logic [7:0] op_q;
  logic [31:0] addr_q;
  logic [31:0] rd_q;
  logic [7:0] cnt_q;
  logic [2:0] shamt_q;
  logic [39:0] sh_q;
  logic [39:0] nsh;
  logic [7:0] ph_q;
  logic go_q;
  logic done_q;
  logic refused_q;
  logic [3:0] io_s1_q;
  logic [3:0] io_s2_q;
  logic tick;
  logic rise;
  logic fall;
  logic ok;
  logic ddr;
  logic band_ok;
  logic [1:0] code_sel;
  logic [2:0] lanes;
  logic [2:0] cur_lanes;
  logic [2:0] abytes;
  logic [7:0] mode;
  logic [7:0] dummy;
  logic [7:0] acyc;
  logic [7:0] dcyc;
  logic [7:0] nmd;
  logic [7:0] ndm;
  frlt_pkg::frlt_ph_e nph;
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic [31:0] stat_v;

  // Lowest band whose limit covers our fixed serial clock rate
  always_comb begin
    band_ok = 1'h1;
    code_sel = frlt_pkg::CODE_SDR_TOP;
    if (ddr) begin
      if (8'(frlt_pkg::SCK_MHZ) <= frlt_pkg::LIM_DDR50) begin
        code_sel = frlt_pkg::CODE_DDR50;
      end else if (8'(frlt_pkg::SCK_MHZ) <= frlt_pkg::LIM_DDR66) begin
        code_sel = frlt_pkg::CODE_DDR66;
      end else begin
        band_ok = 1'h0;
      end
    end else if (8'(frlt_pkg::SCK_MHZ) > frlt_pkg::LIM_SDR_TOP) begin
      band_ok = 1'h0;
    end
  end

  frlt_lookup u_lookup (
    .op(op_q),
    .code(code_sel),
    .ok(ok),
    .ddr(ddr),
    .lanes(lanes),
    .abytes(abytes),
    .mode(mode),
    .dummy(dummy)
  );

  assign acyc = 8'({abytes, 3'h0} / lanes);
  assign dcyc = 8'(8'h20 / {5'h00, lanes});
  assign nmd = mode;
  assign ndm = dummy;
  assign nph = frlt_pkg::frlt_nph(st_q, nmd, ndm);
  assign cur_lanes = (st_q == frlt_pkg::PH_CMD) ? 3'h1 : lanes;

  // Serial clock edges, as seen one pclk before they happen
  assign tick = (ph_q == 8'(frlt_pkg::SCK_HALF - 1));
  assign rise = tick && !lnk.sck;
  assign fall = tick && lnk.sck;

  // Divider; clock rests low outside frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 8'h00;
      lnk.sck <= 1'h0;
    end else if (st_q == frlt_pkg::PH_IDLE) begin
      ph_q <= 8'h00;
      lnk.sck <= 1'h0;
    end else if (tick) begin
      ph_q <= 8'h00;
      lnk.sck <= !lnk.sck;
    end else begin
      ph_q <= ph_q + 8'h01;
    end
  end

  // Lines from the device cross two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
    end else begin
      io_s1_q <= lnk.io;
      io_s2_q <= io_s1_q;
    end
  end

  // Sequencer: phases advance on rising serial clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= frlt_pkg::PH_IDLE;
      cnt_q <= 8'h00;
      shamt_q <= 3'h0;
      rd_q <= 32'h0;
      done_q <= 1'h0;
      refused_q <= 1'h0;
    end else if (st_q == frlt_pkg::PH_IDLE) begin
      if (go_q) begin
        // Unsupported entries never reach the link
        if (ok && band_ok) begin
          st_q <= frlt_pkg::PH_CMD;
          cnt_q <= frlt_pkg::CMD_CYC;
          done_q <= 1'h0;
          refused_q <= 1'h0;
        end else begin
          refused_q <= 1'h1;
        end
      end
    end else if (st_q == frlt_pkg::PH_DONE) begin
      if (fall) begin
        st_q <= frlt_pkg::PH_IDLE;
        done_q <= 1'h1;
      end
    end else if (rise) begin
      cnt_q <= cnt_q - 8'h01;
      shamt_q <= (st_q == frlt_pkg::PH_CMD || st_q == frlt_pkg::PH_ADDR) ?
                 cur_lanes : 3'h0;
      if (st_q == frlt_pkg::PH_DATA) begin
        rd_q <= (rd_q << lanes) |
                {28'h0, frlt_pkg::frlt_get(io_s2_q, lanes, 1'h1)};
      end
      // Exact mode and dummy counts between address and capture
      if (cnt_q == 8'h01) begin
        st_q <= nph;
        cnt_q <= frlt_pkg::frlt_ncnt(nph, nmd, ndm, acyc, dcyc);
      end
    end
  end

  // Line drive: changes on falling serial clock, device samples rising
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= 40'h0;
      lnk.cs_n <= 1'h1;
      lnk.h_io_o <= 4'h0;
      lnk.h_io_oe <= 4'h0;
    end else if (st_q == frlt_pkg::PH_IDLE) begin
      if (go_q && ok && band_ok) begin
        sh_q <= {op_q, (abytes == 3'h4) ? addr_q : {addr_q[23:0], 8'h00}};
        lnk.cs_n <= 1'h0;
        lnk.h_io_o <= {3'h0, op_q[7]};
        lnk.h_io_oe <= 4'h1;
      end
    end else if (fall) begin
      sh_q <= nsh;
      case (st_q)
        frlt_pkg::PH_CMD, frlt_pkg::PH_ADDR, frlt_pkg::PH_MODE: begin
          // Mode bits go out as zeros after the address has drained
          lnk.h_io_o <= frlt_pkg::frlt_put(nsh[39:32], cur_lanes, 1'h0);
          lnk.h_io_oe <= frlt_pkg::frlt_put(8'hff, cur_lanes, 1'h0);
        end
        frlt_pkg::PH_DONE: begin
          lnk.cs_n <= 1'h1;
          lnk.h_io_o <= 4'h0;
          lnk.h_io_oe <= 4'h0;
        end
        default: begin
          lnk.h_io_o <= 4'h0;
          lnk.h_io_oe <= 4'h0;
        end
      endcase
    end
  end

  assign nsh = sh_q << shamt_q;

  // APB decode; every access completes in its first access cycle
  assign wr_acc = psel && penable && pwrite && pready;
  assign rd_setup = psel && !penable;
  assign mapped = (paddr == frlt_pkg::REG_CTRL) ||
                  (paddr == frlt_pkg::REG_ADDR) ||
                  (paddr == frlt_pkg::REG_STAT) ||
                  (paddr == frlt_pkg::REG_DATA);

  always_comb begin
    stat_v = 32'h0;
    stat_v[frlt_pkg::ST_BUSY] = (st_q != frlt_pkg::PH_IDLE) || go_q;
    stat_v[frlt_pkg::ST_DONE] = done_q;
    stat_v[frlt_pkg::ST_REFUSED] = refused_q;
    stat_v[frlt_pkg::ST_CODE +: 2] = code_sel;
  end

  // Answer prepared in the setup cycle, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'h0;
      pslverr <= 1'h0;
    end else begin
      pready <= 1'h1;
      if (rd_setup) begin
        pslverr <= !mapped;
        case (paddr)
          frlt_pkg::REG_CTRL: prdata <= {24'h0, op_q};
          frlt_pkg::REG_ADDR: prdata <= addr_q;
          frlt_pkg::REG_STAT: prdata <= stat_v;
          frlt_pkg::REG_DATA: prdata <= rd_q;
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // Command registers; writes while busy are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= 8'h00;
      addr_q <= 32'h0;
      go_q <= 1'h0;
    end else begin
      go_q <= 1'h0;
      if (wr_acc && st_q == frlt_pkg::PH_IDLE && !go_q) begin
        if (paddr == frlt_pkg::REG_CTRL) begin
          op_q <= pwdata[7:0];
          go_q <= pwdata[frlt_pkg::CTRL_START];
        end
        if (paddr == frlt_pkg::REG_ADDR) begin
          addr_q <= pwdata;
        end
      end
    end
  end
endmodule : frlt_host

// file: testbench/frlt_properties.sv
// Link timing checks for the flash read latency link
`timescale 1ns/1ps
module frlt_properties (
  input wire logic pclk, // Host clock
  input wire logic presetn, // Host reset, active low
  input wire logic sck, // Serial clock
  input wire logic cs_n, // Select, active low
  input wire logic [3:0] h_io_o, // Host line values
  input wire logic [3:0] h_io_oe, // Host enables
  input wire logic [3:0] d_io_oe // Device enables
);
  logic sck_q;
  logic [7:0] rise_q;

  // Rises in this frame; saturates so long frames stay harmless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b0;
      rise_q <= 8'h00;
    end else begin
      sck_q <= sck;
      if (cs_n)
        rise_q <= 8'h00;
      else if (sck && !sck_q && rise_q != 8'hff)
        rise_q <= rise_q + 8'h01;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // First rise a half period after select, then half periods of 4
  sequence wake_s;
    !sck [*3] ##[1:2] sck;
  endsequence
  sequence high_s;
    sck [*3] ##1 !sck;
  endsequence

  idle_sck_a: assert property (cs_n |-> !sck)
    else $error("sck moved while idle");
  wake_sck_a: assert property ($fell(cs_n) |-> wake_s)
    else $error("late first sck rise");
  half_sck_a: assert property ($rose(sck) |=> high_s)
    else $error("sck high time wrong");
  no_clash_a: assert property ((h_io_oe & d_io_oe) == 4'h0)
    else $error("both ends drive a line");
  cmd_drive_a: assert property (!cs_n && rise_q < 8'h08 |->
    h_io_oe[0]) else $error("host not driving command");
  lat_quiet_a: assert property ((!cs_n && rise_q < 8'h10) |->
    d_io_oe == 4'h0) else $error("device drives early");
  host_edge_a: assert property ((!cs_n && $changed(h_io_o)) |->
    !sck) else $error("host changed on sck high");
  dev_edge_a: assert property ((!cs_n && $changed(d_io_oe)) |->
    sck) else $error("device changed off a rise");
  idle_dev_a: assert property (cs_n |-> d_io_oe == 4'h0)
    else $error("device drives while idle");
endmodule : frlt_properties

// file: testbench/tb.sv
// Self-checking bench: host and device joined over the serial link
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, cs_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] lat_code;
  logic [7:0] dev_cmd, last_cmd;
  logic dev_ref, last_ref;
  int n_mismatch, cmp_count, cyc, n_rise;
  // Expected parameter bytes; anything past the end reads as unsupported
  logic [7:0] tbl [22] = '{8'h9a, 8'h2a, 8'h05, 8'h08, 8'h46, 8'h43,
    8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee, 8'h32, 8'h03, 8'h04,
    8'h01, 8'h02, 8'h02, 8'h01, 8'h03, 8'h42, 8'h00};
  logic [7:0] bad_ops [5] = '{8'h03, 8'h3b, 8'h6b, 8'hbb, 8'heb};
  logic [7:0] ddr_ops [6] = '{8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee};

  frlt_if frlt_if_inst ();
  frlt_host frlt_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lnk(frlt_if_inst));
  frlt_dev frlt_dev_inst (.lnk(frlt_if_inst), .lat_code(lat_code),
    .cur_cmd(dev_cmd), .refused(dev_ref));
  frlt_properties frlt_properties_inst (.pclk(pclk), .presetn(presetn),
    .sck(frlt_if_inst.sck), .cs_n(frlt_if_inst.cs_n),
    .h_io_o(frlt_if_inst.h_io_o), .h_io_oe(frlt_if_inst.h_io_oe),
    .d_io_oe(frlt_if_inst.d_io_oe));

  // 200 MHz system clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Any select proves a frame went out on the link
  always @(negedge frlt_if_inst.cs_n) cs_seen = 1'b1;

  // Serial clock rises in the current frame
  always @(posedge frlt_if_inst.sck) n_rise++;

  // Device status as it stands just before chip select clears it
  always @(posedge frlt_if_inst.cs_n) begin
    last_cmd = dev_cmd;
    last_ref = dev_ref;
  end

  // Hang guard; real run is well under a third of this
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; entered just after an edge, ends one edge after release
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Reference word: four bytes from the start offset, first byte on top
  function automatic logic [31:0] model(input logic [7:0] op,
      input logic [7:0] a);
    logic [31:0] w;
    logic [7:0] b;
    w = 32'h0;
    for (int k = 0; k < 4; k++) begin
      b = a + k[7:0];
      if (op == 8'h5b) b = (b < 8'h16) ? tbl[b] : 8'hff;
      w = {w[23:0], b};
    end
    return w;
  endfunction : model

  // Rises of a whole frame: command, address, mode, dummy, four bytes
  function automatic int rises(input logic [7:0] op);
    case (op)
      8'h0d: return 8 + 24 + 4 + 1 + 32;
      8'h0e: return 8 + 32 + 4 + 1 + 32;
      8'hbd: return 8 + 12 + 2 + 2 + 16;
      8'hbe: return 8 + 16 + 2 + 2 + 16;
      8'hed: return 8 + 6 + 1 + 3 + 8;
      8'hee: return 8 + 8 + 1 + 3 + 8;
      default: return 8 + 24 + 0 + 8 + 32;
    endcase
  endfunction : rises

  // Start one read, wait for the host to go idle, check status and data
  task automatic run(input logic [7:0] op, input logic [1:0] code,
      input logic bad, input logic [31:0] a);
    int n;
    lat_code <= code;
    cs_seen = 1'b0;
    n_rise = 0;
    apb(1'b1, 8'h04, a);
    apb(1'b1, 8'h00, {23'h0, 1'b1, op});
    n = 0;
    do begin
      apb(1'b0, 8'h08, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 1000);
    chk({30'h0, rd[2], rd[0]}, {30'h0, bad, 1'b0});
    chk({31'h0, cs_seen}, {31'h0, ~bad});
    if (!bad) begin
      chk({29'h0, rd[5:4], rd[1]}, {29'h0, code, 1'b1});
      chk(n_rise, rises(op));
      chk({23'h0, last_ref, last_cmd}, {24'h0, op});
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, model(op, a[7:0]));
    end
  endtask : run

  initial begin
    {presetn, psel, penable, pwrite, err, cs_seen} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lat_code = 2'h2;
    void'($urandom(51));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h0);
    apb(1'b1, 8'h14, 32'hffff_ffff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    foreach (bad_ops[i])
      run(bad_ops[i], 2'h2, 1'b1, $urandom());
    run(8'h0b, 2'h2, 1'b0, $urandom());
    foreach (ddr_ops[i])
      run(ddr_ops[i], 2'h3, 1'b0, $urandom());
    for (int i = 0; i < 6; i++)
      run(8'h5b, 2'h2, 1'b0, {24'h0, i[5:0], 2'h0});
    stop_test();
  end
endmodule : tb
